// ==== vram_host_ctrl.sv ====
// Host controller for a dual-port video DRAM: block writes and transfer cycles over AHB-Lite.
// Operation
// - Data pins at column strobe fall select which of the four columns get color.
// - Flag level at each column strobe fall picks block write or plain access.
// - Column strobe high and transfer strobe low at row fall mean transfer.
// - Transfer column sets serial start; read or pseudo transfer needed first.
// - Host raises the transfer strobe again to complete a read transfer.
// - Host keeps serial accesses apart from the transfer strobe rise.
// - Host releases serial pins before the first access after a read transfer.
// - Host keeps shift clock low during pseudo or write transfer, then waits.
// - Host waits after row strobe fall before driving serial pins in pseudo.
// - Write-back row top bit must match the row of the earlier read.
`timescale 1ns/1ps
`include "vram_host_consts.svh"
module vram_host_ctrl (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // DRAM port pins
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             transfer_or_output_strobe_n,
  output logic             special_function_flag,
  output logic [8:0]       addr,
  output logic [3:0]       dq_out,
  output logic             dq_oe,
  // Serial port pins
  output logic             serial_shift_clock,
  output logic             serial_port_enable_n,
  output logic [3:0]       sdq_out,
  output logic             sdq_oe,
  input  wire logic [3:0]  sdq_in,
  input  wire logic        half_indicator_output
);
  import vram_host_pkg::*;

  ctrl_state_type r;
  ctrl_state_type next_r;
  logic           hreadyout_q;
  serial_bus_if   sbus ();

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] read_value(input logic [7:0] a, input ctrl_state_type s,
                                             input logic [3:0] srd, input logic sbusy);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `REG_CMD:    v[2:0] = s.op;
      `REG_ROW:    v[8:0] = s.row;
      `REG_COL:    v[8:0] = s.col;
      `REG_MASK:   v[7:0] = {s.col_select, s.plane_mask};
      `REG_STATUS: begin
        v[`STAT_BUSY] = (s.state != ST_IDLE);
        v[`STAT_SERIAL_OUT] = s.serial_out;
        v[`STAT_POINTER_SET] = s.pointer_set;
        v[`STAT_HALF] = s.half_sync;
        v[`STAT_SERIAL_BUSY] = sbusy;
        v[`STAT_REFUSED] = s.refused;
        v[`STAT_DONE] = s.done;
      end
      `REG_SERIAL: v[3:0] = srd;
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic is_transfer(input op_type o);
    return (o != OP_BLOCK) && (o != OP_BLOCK_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_r = r;
    next_r.serial_start = 1'b0;
    next_r.half_meta = half_indicator_output;
    next_r.half_sync = r.half_meta;

    // Address phase: read data is prepared here so the slave never inserts waits.
    next_r.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = haddr[7:0];
      next_r.hrdata = read_value(haddr[7:0], r, sbus.rdata, sbus.busy);
    end

    // Data phase of a write.
    if (r.wr_pend) begin
      case (r.wr_addr)
        `REG_ROW:  next_r.row = hwdata[8:0];
        `REG_COL:  next_r.col = hwdata[8:0];
        `REG_MASK: begin
          next_r.plane_mask = hwdata[`MASK_PLANE_LSB +: 4];
          next_r.col_select = hwdata[`MASK_COLSEL_LSB +: 4];
        end
        `REG_STATUS: begin
          if (hwdata[`STAT_REFUSED]) begin
            next_r.refused = 1'b0;
          end
          if (hwdata[`STAT_DONE]) begin
            next_r.done = 1'b0;
          end
        end
        `REG_CMD: begin
          // same top row bit
          // A write transfer that would land on the other half row is refused.
          if (r.state != ST_IDLE || hwdata[2:0] > `OP_LAST ||
              (op_type'(hwdata[2:0]) == OP_WRITE_XFER &&
               r.row[`ROW_TOP_BIT] != r.read_top)) begin
            next_r.refused = 1'b1;
          end else begin
            next_r.op = op_type'(hwdata[2:0]);
            next_r.state = ST_SETUP;
            next_r.cnt = 8'(`STROBE_CYC);
            next_r.done = 1'b0;
            next_r.addr = r.row;
            next_r.ras_n = 1'b1;
            next_r.cas_n = 1'b1;
            // decode levels set
            // All decode levels but the serial enable, which follows one cycle later, are settled a full strobe time
            // before the row strobe falls and stay put until the column address goes out.
            if (is_transfer(op_type'(hwdata[2:0]))) begin
              next_r.xfer_n = 1'b0;
              next_r.inhibit = 1'b1;
              next_r.dq_oe = 1'b0;
              next_r.we_n = (op_type'(hwdata[2:0]) == OP_READ_XFER ||
                             op_type'(hwdata[2:0]) == OP_SPLIT_READ);
              next_r.sff = (op_type'(hwdata[2:0]) == OP_SPLIT_READ);
              next_r.se_low = (op_type'(hwdata[2:0]) == OP_WRITE_XFER);
            end else begin
              next_r.xfer_n = 1'b1;
              next_r.sff = 1'b0;
              next_r.we_n = (op_type'(hwdata[2:0]) == OP_BLOCK);
              next_r.dq_out = r.plane_mask;
              next_r.dq_oe = (op_type'(hwdata[2:0]) == OP_BLOCK_MASK);
            end
          end
        end
        `REG_SERIAL: begin
          // start pointer first
          // No shift clock before a read or pseudo transfer has set the start pointer.
          if (!r.pointer_set || r.inhibit || sbus.busy) begin
            next_r.refused = 1'b1;
          end else begin
            next_r.serial_start = 1'b1;
            next_r.serial_wdata = hwdata[3:0];
          end
        end
        default: begin
          next_r.refused = r.refused;
        end
      endcase
    end

    // Strobe sequencer.
    if (r.state != ST_IDLE && r.cnt > 8'h01) begin
      next_r.cnt = r.cnt - 8'h01;
    end else begin
      next_r.cnt = 8'(`STROBE_CYC);
      case (r.state)
        ST_IDLE: begin
          next_r.cnt = 8'(`STROBE_CYC);
        end
        ST_SETUP: begin
          next_r.state = ST_RAS;
          next_r.ras_n = 1'b0;
        end
        ST_RAS: begin
          next_r.state = ST_COL;
          next_r.addr = r.col;
          if (!is_transfer(r.op)) begin
            next_r.addr = {r.col[8:2], 2'b00};
            next_r.sff = 1'b1;
            next_r.dq_out = r.col_select;
            next_r.dq_oe = 1'b1;
            next_r.we_n = 1'b0;
          end
        end
        ST_COL: begin
          if (!is_transfer(r.op)) begin
            next_r.state = ST_CAS;
            next_r.cas_n = 1'b0;
          end else if (r.op == OP_READ_XFER) begin
            next_r.state = ST_DT_RISE;
            next_r.xfer_n = 1'b1;
          end else begin
            next_r.state = ST_RAS_END;
            next_r.ras_n = 1'b1;
          end
        end
        ST_CAS: begin
          next_r.state = ST_CAS_END;
          next_r.cas_n = 1'b1;
          next_r.sff = 1'b0;
          next_r.we_n = 1'b1;
          next_r.dq_oe = 1'b0;
        end
        ST_CAS_END, ST_DT_RISE: begin
          next_r.state = ST_RAS_END;
          next_r.ras_n = 1'b1;
        end
        ST_RAS_END: begin
          next_r.xfer_n = 1'b1;
          next_r.sff = 1'b0;
          next_r.we_n = 1'b1;
          next_r.dq_oe = 1'b0;
          next_r.se_low = 1'b0;
          next_r.state = ST_RECOVER;
          next_r.cnt = 8'(`SERIAL_REC_CYC);
        end
        ST_RECOVER: begin
          // serial kept apart
          // For transfers the serial port stays blocked from setup through this wait, which covers
          // both sides of the transfer strobe rise and the recovery after row rise.
          next_r.state = ST_IDLE;
          next_r.inhibit = 1'b0;
          next_r.done = 1'b1;
          if (r.op == OP_READ_XFER) begin
            next_r.serial_out = 1'b1;
          end else if (r.op == OP_PSEUDO_XFER || r.op == OP_WRITE_XFER) begin
            next_r.serial_out = 1'b0;
          end
          if (r.op == OP_READ_XFER || r.op == OP_PSEUDO_XFER) begin
            next_r.pointer_set = 1'b1;
          end
          if (r.op == OP_READ_XFER || r.op == OP_SPLIT_READ) begin
            next_r.read_top = r.row[`ROW_TOP_BIT];
          end
        end
        default: begin
          next_r.state = ST_IDLE;
          next_r.inhibit = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{state: ST_IDLE, op: OP_BLOCK, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
             xfer_n: 1'b1, default: '0};
      hreadyout_q <= 1'b0;
    end else begin
      r <= next_r;
      hreadyout_q <= 1'b1;
    end
  end

  // The engine's own shift logic relies on the device pointer stepping per rise.
  // one rise per access
  serial_port_engine u_serial (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .sbus                 (sbus),
    .serial_shift_clock   (serial_shift_clock),
    .serial_port_enable_n (serial_port_enable_n),
    .sdq_out              (sdq_out),
    .sdq_oe               (sdq_oe),
    .sdq_in               (sdq_in)
  );

  // colors preloaded
  // Color registers are loaded by other cycles; this host only uses them.
  assign sbus.start = r.serial_start;
  assign sbus.drive = !r.serial_out;
  assign sbus.wdata = r.serial_wdata;
  assign sbus.inhibit = r.inhibit;
  assign sbus.se_low = r.se_low;

  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign ras_n = r.ras_n;
  assign cas_n = r.cas_n;
  assign we_n = r.we_n;
  assign transfer_or_output_strobe_n = r.xfer_n;
  assign special_function_flag = r.sff;
  assign addr = r.addr;
  assign dq_out = r.dq_out;
  assign dq_oe = r.dq_oe;
endmodule

// ==== vram_host_consts.svh ====
// Register offsets, field positions and timing constants of the video DRAM host controller.
`ifndef VRAM_HOST_CONSTS_SVH
`define VRAM_HOST_CONSTS_SVH

`define CLK_PERIOD_NS     10
`define T_STROBE_NS       40
`define T_SERIAL_REC_NS   30
`define T_SC_HIGH_NS      20
`define STROBE_CYC        (((`T_STROBE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define SERIAL_REC_CYC    (((`T_SERIAL_REC_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define SC_HIGH_CYC       (((`T_SC_HIGH_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define SYNC_CYC          2

`define REG_CMD           8'h00
`define REG_ROW           8'h04
`define REG_COL           8'h08
`define REG_MASK          8'h0C
`define REG_STATUS        8'h10
`define REG_SERIAL        8'h14

`define MASK_PLANE_LSB    0
`define MASK_COLSEL_LSB   4
`define STAT_BUSY         0
`define STAT_SERIAL_OUT   1
`define STAT_POINTER_SET  2
`define STAT_HALF         3
`define STAT_SERIAL_BUSY  4
`define STAT_REFUSED      5
`define STAT_DONE         6
`define ROW_TOP_BIT       8
`define OP_LAST           3'h5

`endif

// ==== vram_host_pkg.sv ====
// Types shared by the video DRAM host controller modules.
package vram_host_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_SETUP    = 4'h1,
    ST_RAS      = 4'h2,
    ST_COL      = 4'h3,
    ST_CAS      = 4'h4,
    ST_CAS_END  = 4'h5,
    ST_DT_RISE  = 4'h6,
    ST_RAS_END  = 4'h7,
    ST_RECOVER  = 4'h8
  } seq_state_type;

  typedef enum logic [2:0] {
    OP_BLOCK       = 3'h0,
    OP_BLOCK_MASK  = 3'h1,
    OP_READ_XFER   = 3'h2,
    OP_PSEUDO_XFER = 3'h3,
    OP_WRITE_XFER  = 3'h4,
    OP_SPLIT_READ  = 3'h5
  } op_type;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_SETUP = 2'h1,
    PH_HIGH  = 2'h2,
    PH_LOW   = 2'h3
  } serial_phase_type;

  typedef struct packed {
    seq_state_type state;
    logic [7:0]    cnt;
    op_type        op;
    logic [8:0]    row;
    logic [8:0]    col;
    logic [3:0]    plane_mask;
    logic [3:0]    col_select;
    logic          pointer_set;
    logic          serial_out;
    logic          read_top;
    logic          refused;
    logic          done;
    logic          inhibit;
    logic          se_low;
    logic          serial_start;
    logic [3:0]    serial_wdata;
    logic          ras_n;
    logic          cas_n;
    logic          we_n;
    logic          xfer_n;
    logic          sff;
    logic [8:0]    addr;
    logic [3:0]    dq_out;
    logic          dq_oe;
    logic          wr_pend;
    logic [7:0]    wr_addr;
    logic [31:0]   hrdata;
    logic          half_meta;
    logic          half_sync;
  } ctrl_state_type;

  typedef struct packed {
    serial_phase_type phase;
    logic [7:0]       cnt;
    logic             sc;
    logic             se_n;
    logic [3:0]       sdq_out;
    logic             sdq_oe;
    logic [3:0]       rdata;
    logic [3:0]       meta;
    logic [3:0]       sync;
  } serial_state_type;

endpackage

// ==== serial_bus_if.sv ====
// Link between the strobe sequencer and the serial port engine.
`timescale 1ns/1ps
interface serial_bus_if;
  logic       start;
  logic       drive;
  logic [3:0] wdata;
  logic       inhibit;
  logic       se_low;
  logic [3:0] rdata;
  logic       busy;

  modport ctrl (output start, drive, wdata, inhibit, se_low, input rdata, busy);
  modport engine (input start, drive, wdata, inhibit, se_low, output rdata, busy);
endinterface

// ==== serial_port_engine.sv ====
// Serial port engine: one shift clock per access, drives or samples the serial pins.
`timescale 1ns/1ps
`include "vram_host_consts.svh"
module serial_port_engine (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Sequencer side
  serial_bus_if.engine    sbus,
  // Serial pins
  output logic            serial_shift_clock,
  output logic            serial_port_enable_n,
  output logic [3:0]      sdq_out,
  output logic            sdq_oe,
  input  wire logic [3:0] sdq_in
);
  import vram_host_pkg::*;

  serial_state_type r;
  serial_state_type next_r;

  always_comb begin
    next_r = r;
    next_r.meta = sdq_in;
    next_r.sync = r.meta;
    // hold clock low
    // While a transfer holds the row strobe low the shift clock never rises and the
    // enable takes the level that the transfer decode expects.
    if (r.phase == PH_IDLE) begin
      next_r.se_n = !sbus.se_low;
    end
    case (r.phase)
      PH_IDLE: begin
        next_r.sc = 1'b0;
        next_r.sdq_oe = 1'b0;
        if (sbus.start && !sbus.inhibit) begin
          next_r.phase = PH_SETUP;
          next_r.se_n = 1'b0;
          next_r.sdq_out = sbus.wdata;
          next_r.sdq_oe = sbus.drive;
          next_r.cnt = 8'(`SC_HIGH_CYC);
        end
      end
      PH_SETUP: begin
        next_r.phase = PH_HIGH;
        next_r.sc = 1'b1;
      end
      PH_HIGH: begin
        if (r.cnt <= 8'h01) begin
          next_r.phase = PH_LOW;
          next_r.sc = 1'b0;
          next_r.cnt = 8'(`SC_HIGH_CYC + `SYNC_CYC);
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      PH_LOW: begin
        if (r.cnt <= 8'h01) begin
          next_r.phase = PH_IDLE;
          next_r.rdata = r.sync;
          // release before access
          // Drive is dropped after every access so the pins are left undriven until the next access starts.
          next_r.sdq_oe = 1'b0;
          next_r.se_n = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
        next_r.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{phase: PH_IDLE, se_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign serial_shift_clock = r.sc;
  assign serial_port_enable_n = r.se_n;
  assign sdq_out = r.sdq_out;
  assign sdq_oe = r.sdq_oe;
  assign sbus.rdata = r.rdata;
  assign sbus.busy = (r.phase != PH_IDLE);
endmodule

// ==== vram_dev_model.sv ====
// Pin-level model of the dual-port video DRAM.
`timescale 1ns/1ps
module vram_dev_model (
  // Array port
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       xfer_n,
  input  wire logic       flag,
  input  wire logic [8:0] addr,
  input  wire logic [3:0] dq_out,
  // Serial port
  input  wire logic       sc,
  input  wire logic       se_n,
  input  wire logic [3:0] sdq_out,
  input  wire logic       sdq_oe,
  output logic [3:0]      sdq_in,
  output logic            half
);
  logic [3:0] serial_access_memory [512];
  logic [3:0] color [4];
  logic [2:0] kind = 3'h0;
  logic [8:0] row, nxt, bw_addr;
  logic [8:0] ptr = 9'h000;
  logic [3:0] bw_sel, mask;
  logic [3:0] dout = 4'h0;
  logic       dir_out = 1'b0;
  logic       pend = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // decode once
  always @(negedge ras_n) begin
    row <= addr;
    kind <= (!xfer_n && cas_n) ? {1'b1, we_n, flag} : 3'h0;
    mask <= we_n ? 4'hF : dq_out;
  end
  always @(negedge cas_n) begin
    if (flag) begin
      bw_addr <= addr;
      bw_sel <= dq_out;
    end
  end
  always @(posedge xfer_n) begin
    if (!ras_n && kind == 3'h6) begin
      foreach (serial_access_memory[i]) serial_access_memory[i] = row[3:0] ^ 4'(i);
      ptr = addr;
      dir_out = 1'b1;
    end
  end
  always @(posedge ras_n) begin
    if (kind == 3'h4) begin
      ptr = addr;
      dir_out = 1'b0;
    end
    if (kind == 3'h7) begin
      for (int i = 0; i < 256; i++) serial_access_memory[{~ptr[8], 8'(i)}] = row[3:0] ^ 4'(i);
      nxt = {~ptr[8], addr[7:0]};
      pend = 1'b1;
    end
    kind = 3'h0;
  end
  always @(posedge sc) begin
    dout <= serial_access_memory[ptr];
    if (!dir_out && !se_n) serial_access_memory[ptr] <= sdq_in;
    ptr <= (pend && ptr[7:0] == 8'hFF) ? nxt : ptr + 9'h001;
    if (ptr[7:0] == 8'hFF) pend <= 1'b0;
  end
  assign half = ptr[8];
  // wire level; an undriven line shows the inverse of the last data.
  assign sdq_in = (dir_out && !se_n) ? dout : (sdq_oe ? sdq_out : ~dout);
endmodule

// ==== vram_host_ctrl_sva.sv ====
// Pin protocol checker for the video DRAM host controller.
`timescale 1ns/1ps
module vram_host_ctrl_sva (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Watched outputs
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       transfer_or_output_strobe_n,
  input wire logic       special_function_flag,
  input wire logic [8:0] addr,
  input wire logic       dq_oe,
  input wire logic       serial_shift_clock
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  ready_ok_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus not ready");
  blk_flag_a: assert property ($fell(cas_n) |-> special_function_flag)
    else $error("flag low at column fall");
  blk_col_a: assert property ($fell(cas_n) |-> addr[1:0] == 2'h0)
    else $error("group not aligned");
  blk_sel_a: assert property ($fell(cas_n) |-> dq_oe && !we_n)
    else $error("no column select");
  xfer_dec_a: assert property ($fell(ras_n) && !transfer_or_output_strobe_n |-> cas_n)
    else $error("transfer with column low");
  mask_drv_a: assert property ($fell(ras_n) && !we_n && transfer_or_output_strobe_n
    |-> dq_oe)
    else $error("mask not driven");
  rd_rise_a: assert property ($fell(ras_n) && !transfer_or_output_strobe_n && we_n
    && !special_function_flag |-> ##[1:12] ($rose(transfer_or_output_strobe_n) && !ras_n))
    else $error("read transfer not completed");
  sc_ras_a: assert property (serial_shift_clock |-> ras_n)
    else $error("shift clock in row cycle");
endmodule

// ==== test_vram_host_ctrl.sv ====
// Self-checking bench for the video DRAM host controller.
`timescale 1ns/1ps
module test_vram_host_ctrl;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        rd_ph = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic        hreadyout, hresp, ras_n, cas_n, we_n, xfer_n, flag, dq_oe;
  logic        sc, se_n, sdq_oe, half;
  logic [31:0] hrdata, r;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [8:0]  addr, col;
  logic [3:0]  dq_out, sdq_out, sdq_in, sel, pm, d;
  int          errors = 0;
  int          comparisons = 0;
  always #5 hclk = ~hclk;
  vram_host_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .transfer_or_output_strobe_n(xfer_n), .special_function_flag(flag),
    .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .serial_shift_clock(sc),
    .serial_port_enable_n(se_n), .sdq_out(sdq_out), .sdq_oe(sdq_oe), .sdq_in(sdq_in),
    .half_indicator_output(half));
  vram_dev_model dev_u (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .xfer_n(xfer_n),
    .flag(flag), .addr(addr), .dq_out(dq_out), .sc(sc), .se_n(se_n), .sdq_out(sdq_out),
    .sdq_oe(sdq_oe), .sdq_in(sdq_in), .half(half));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      end_sim();
    end
  endtask
  // One single word transfer; a read notes its expected value for the monitor.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    wt();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? e : 32'h0;
    wt();
    r = hrdata;
  endtask
  task automatic wb(input int b, input logic v);
    int n = 0;
    do begin
      bus(0, 8'h10, 0, 0);
      n++;
    end while (r[b] !== v && n < 40);
    if (n >= 40) begin
      errors++;
      end_sim();
    end
  endtask
  task automatic run(input logic [2:0] op);
    bus(1, 8'h00, 32'(op), 0);
    wb(6, 1'b1);
    bus(1, 8'h10, 32'h60, 0);
  endtask
  task automatic ser(input logic [3:0] v);
    bus(1, 8'h14, 32'(v), 0);
    wb(4, 1'b0);
  endtask
  always @(posedge hclk) begin
    if (rd_ph && mq.size() > 0) begin
      if (mq[0] != 0) chk("hrdata", eq[0] & mq[0], hrdata & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h99E1));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h10, 32'h0, 32'h7);
    bus(1, 8'h20, 32'hFFFFFFFF, 0);
    bus(0, 8'h20, 32'h0, 32'hFFFFFFFF);
    bus(1, 8'h14, 32'h5, 0);
    bus(0, 8'h10, 32'h20, 32'h30);
    bus(1, 8'h10, 32'h60, 0);
    for (int op = 0; op < 2; op++) begin
      col = 9'($urandom);
      sel = 4'($urandom);
      pm = 4'($urandom);
      bus(1, 8'h04, 32'h1A5, 0);
      bus(1, 8'h08, 32'(col), 0);
      bus(1, 8'h0C, 32'({sel, pm}), 0);
      run(3'(op));
      chk("group", 32'({col[8:2], 2'h0}), 32'(dev_u.bw_addr));
      chk("select", 32'(sel), 32'(dev_u.bw_sel));
      chk("mask", op ? 32'(pm) : 32'hF, 32'(dev_u.mask));
    end
    bus(1, 8'h04, 32'h0A3, 0);
    bus(1, 8'h08, 32'h0FE, 0);
    run(3'h2);
    bus(0, 8'h10, 32'h6, 32'h6);
    for (int k = 0; k < 2; k++) begin
      ser(4'h0);
      bus(0, 8'h14, 32'(4'hD ^ 4'(k)), 32'hF);
    end
    bus(0, 8'h10, 32'h8, 32'h8);
    bus(1, 8'h04, 32'h1A3, 0);
    bus(1, 8'h00, 32'h4, 0);
    bus(0, 8'h10, 32'h20, 32'h21);
    bus(1, 8'h10, 32'h60, 0);
    bus(1, 8'h04, 32'h0A5, 0);
    bus(1, 8'h08, 32'h010, 0);
    run(3'h5);
    bus(0, 8'h10, 32'h2, 32'h2);
    repeat (256) ser(4'h0);
    bus(0, 8'h10, 32'h0, 32'h8);
    ser(4'h0);
    bus(0, 8'h14, 32'h5, 32'hF);
    bus(1, 8'h08, 32'h033, 0);
    run(3'h3);
    bus(0, 8'h10, 32'h4, 32'h6);
    d = 4'($urandom);
    ser(d);
    chk("stored", 32'(d), 32'(dev_u.serial_access_memory[9'h033]));
    bus(1, 8'h04, 32'h0B0, 0);
    run(3'h4);
    bus(0, 8'h10, 32'h4, 32'h26);
    chk("start", 32'h033, 32'(dev_u.ptr));
    bus(1, 8'h00, 32'h6, 0);
    bus(0, 8'h10, 32'h20, 32'h21);
    end_sim();
  end
endmodule
bind vram_host_ctrl vram_host_ctrl_sva sva_u (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .transfer_or_output_strobe_n(transfer_or_output_strobe_n),
  .special_function_flag(special_function_flag), .addr(addr), .dq_oe(dq_oe),
  .serial_shift_clock(serial_shift_clock));
